/* fdc_host_regs.sv */
// host register bank of a legacy diskette controller, eight byte offsets
// assumes one decoded I/O cycle per request pulse; drive pins are asynchronous
//
// Overview of operation
// - first command byte bit 6 picks encoding: 0 gives FM, 1 gives MFM.
// - registers decode at offsets 0 to 7 from an 8-byte aligned base.
// - offset 4 reads main status, writes rate; offset 7 reads input, writes config.
// - bits mirroring floating drive pins read back as one.
// - no media sensing, no high rate output, no second select or motor pin.
// - PC-AT and PS/2 modes; fields behave alike unless marked mode-specific.
// - status A, status B and full digital input exist only in PS/2 mode.
// - in PC-AT mode digital input carries only disk change in bit 7.
// - enhanced tape mode shows upper bits 1111 and a logical drive exchange field.
`timescale 1ns/1ps
module fdc_host_regs
  import fdc_regs_pkg::*;
#(
  parameter logic [15:0] BASE_ADDR = BASE_DEFAULT,
  parameter logic [3:0] COMMAND_BYTES = CMD_BYTES
) (
  input wire logic CLK_SYS,
  input wire logic RESETN,
  input wire io_req_t IO_REQ,
  output io_rsp_t IO_RSP,
  input wire logic PS2_MODE,
  input wire logic ENH_TAPE_MODE,
  input wire logic PINS_FLOATING,
  input wire logic INDEX_N,
  input wire logic TRACK0_N,
  input wire logic WRITE_PROTECT_N,
  input wire logic DISK_CHANGED_N,
  output logic DRIVE_SELECT_0_N,
  output logic MOTOR_ON_0_N,
  output logic RATE_SELECT_LOW,
  output logic MFM_MODE,
  output logic CTRL_RESET,
  output logic LOW_POWER
);

  ////////////////////////////////////////////////////////////////////////////
  // reset release

  logic rst_s1_r;
  logic rst_n_r;

  always_ff @(posedge CLK_SYS or negedge RESETN) begin
    if (!RESETN) begin
      rst_s1_r <= 1'b0;
      rst_n_r <= 1'b0;
    end else begin
      rst_s1_r <= 1'b1;
      rst_n_r <= rst_s1_r;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // drive pin synchronisers: a change counts once stages two and three agree

  logic [NUM_PINS-1:0] pin_raw;
  logic [NUM_PINS-1:0] pin_s1_r;
  logic [NUM_PINS-1:0] pin_s2_r;
  logic [NUM_PINS-1:0] pin_s3_r;
  logic [NUM_PINS-1:0] pin_r;

  // pins are active low; stored active high
  assign pin_raw = {~DISK_CHANGED_N, ~WRITE_PROTECT_N, ~TRACK0_N, ~INDEX_N};

  genvar gi;
  generate
    for (gi = 0; gi < NUM_PINS; gi++) begin : g_pin
      always_ff @(posedge CLK_SYS or negedge rst_n_r) begin
        if (!rst_n_r) begin
          pin_s1_r[gi] <= 1'b0;
          pin_s2_r[gi] <= 1'b0;
          pin_s3_r[gi] <= 1'b0;
          pin_r[gi] <= 1'b0;
        end else begin
          pin_s1_r[gi] <= pin_raw[gi];
          pin_s2_r[gi] <= pin_s1_r[gi];
          pin_s3_r[gi] <= pin_s2_r[gi];
          if (pin_s2_r[gi] == pin_s3_r[gi]) begin
            pin_r[gi] <= pin_s3_r[gi];
          end
        end
      end
    end
  endgenerate

  // a tristated drive interface reads as all ones
  function automatic logic pin_bit(input logic v, input logic floating);
    pin_bit = floating ? 1'b1 : v;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // address decode

  logic hit;
  logic wr_hit;
  logic rd_hit;
  logic [2:0] off;

  // low three address bits select; the rest must match the aligned base
  assign hit = (IO_REQ.addr & ~BASE_ALIGN_MASK) == (BASE_ADDR & ~BASE_ALIGN_MASK);
  assign off = IO_REQ.addr[2:0];
  assign wr_hit = hit && IO_REQ.wr;
  assign rd_hit = hit && IO_REQ.rd;

  function automatic logic is_wr(input logic w, input logic [2:0] o, input logic [2:0] t);
    is_wr = w && (o == t);
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // digital output, tape drive and rate registers

  logic [7:0] dor_r;
  logic [1:0] tape_sel_r;
  logic [1:0] exchange_r;
  logic [1:0] rate_r;
  logic [2:0] precomp_r;
  logic low_power_r;
  logic sw_reset_r;
  logic ctrl_reset;

  assign ctrl_reset = !dor_r[DOR_RESET_N] || sw_reset_r;

  always_ff @(posedge CLK_SYS or negedge rst_n_r) begin
    if (!rst_n_r) begin
      dor_r <= RST_DIGITAL_OUTPUT;
    end else if (is_wr(wr_hit, off, OFF_DIGITAL_OUTPUT)) begin
      dor_r <= IO_REQ.wdata;
    end
  end

  always_ff @(posedge CLK_SYS or negedge rst_n_r) begin
    if (!rst_n_r) begin
      tape_sel_r <= RST_TAPE_SELECT;
      exchange_r <= RST_EXCHANGE;
    end else if (is_wr(wr_hit, off, OFF_TAPE_DRIVE)) begin
      tape_sel_r <= IO_REQ.wdata[1:0];
      // exchange field only exists in enhanced mode
      if (ENH_TAPE_MODE) begin
        exchange_r <= IO_REQ.wdata[3:2];
      end
    end
  end

  // offset 4 writes land in rate select, offset 7 writes in config control
  always_ff @(posedge CLK_SYS or negedge rst_n_r) begin
    if (!rst_n_r) begin
      rate_r <= RST_RATE;
      precomp_r <= RST_PRECOMP;
      low_power_r <= 1'b0;
      sw_reset_r <= 1'b0;
    end else begin
      // software reset lasts one cycle then self-clears
      sw_reset_r <= 1'b0;
      // any write hit wakes the part; a rate write that sets the bit again wins
      if (low_power_r && wr_hit) begin
        low_power_r <= 1'b0;
      end
      if (is_wr(wr_hit, off, OFF_MAIN_STATUS)) begin
        rate_r <= IO_REQ.wdata[DSR_RATE +: 2];
        precomp_r <= IO_REQ.wdata[DSR_PRECOMP +: 3];
        low_power_r <= IO_REQ.wdata[DSR_LOW_POWER];
        sw_reset_r <= IO_REQ.wdata[DSR_SW_RESET];
      end else if (is_wr(wr_hit, off, OFF_DIGITAL_INPUT)) begin
        rate_r <= IO_REQ.wdata[DSR_RATE +: 2];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // command byte intake; execution engine lives elsewhere

  typedef enum logic [1:0] {
    CMD_IDLE = 2'b01,
    CMD_PARAMS = 2'b10
  } cmd_state_t;

  cmd_state_t cmd_state_r;
  logic [3:0] cmd_cnt_r;
  logic mfm_r;
  logic [7:0] last_byte_r;
  logic fifo_wr;

  assign fifo_wr = is_wr(wr_hit, off, OFF_DATA_FIFO);

  always_ff @(posedge CLK_SYS or negedge rst_n_r) begin
    if (!rst_n_r) begin
      cmd_state_r <= CMD_IDLE;
      cmd_cnt_r <= 4'h0;
    end else if (ctrl_reset) begin
      cmd_state_r <= CMD_IDLE;
      cmd_cnt_r <= 4'h0;
    end else if (fifo_wr) begin
      unique case (cmd_state_r)
        CMD_IDLE: begin
          cmd_cnt_r <= 4'h1;
          cmd_state_r <= (COMMAND_BYTES > 4'h1) ? CMD_PARAMS : CMD_IDLE;
        end
        CMD_PARAMS: begin
          cmd_cnt_r <= cmd_cnt_r + 4'h1;
          if (cmd_cnt_r + 4'h1 >= COMMAND_BYTES) begin
            cmd_state_r <= CMD_IDLE;
          end
        end
      endcase
    end
  end

  always_ff @(posedge CLK_SYS or negedge rst_n_r) begin
    if (!rst_n_r) begin
      mfm_r <= 1'b0;
      last_byte_r <= 8'h00;
    end else if (fifo_wr) begin
      last_byte_r <= IO_REQ.wdata;
      if (cmd_state_r == CMD_IDLE && !ctrl_reset) begin
        mfm_r <= IO_REQ.wdata[CMD_MFM_BIT];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // read mux; reads have no side effects on any register

  logic [7:0] rd_nxt;
  logic [7:0] status_a;
  logic [7:0] status_b;
  logic [7:0] tape_rd;
  logic [7:0] main_status;
  logic [7:0] dir_rd;
  logic hd;
  logic fl;

  assign fl = PINS_FLOATING;
  assign hd = (rate_r == 2'h0) || (rate_r == 2'h3);
  assign status_a = {1'b0, 1'b0, 1'b0, pin_bit(pin_r[PIN_TRACK0], fl), 1'b0,
                     pin_bit(pin_r[PIN_INDEX], fl), pin_bit(pin_r[PIN_WPROT], fl), 1'b0};
  assign status_b = {2'b00, dor_r[DOR_SEL], 3'b000, dor_r[DOR_MOTOR1], dor_r[DOR_MOTOR0]};
  assign tape_rd = ENH_TAPE_MODE ? {TAPE_UPPER_ONES, exchange_r, tape_sel_r}
                                 : {6'h00, tape_sel_r};
  assign main_status = {!ctrl_reset, 1'b0, 1'b0, cmd_state_r == CMD_PARAMS, 2'b00, 2'b00};

  always_comb begin
    dir_rd = {pin_bit(pin_r[PIN_CHANGED], fl), 7'h00};
    if (PS2_MODE) begin
      dir_rd = {pin_bit(pin_r[PIN_CHANGED], fl), 4'h0, rate_r, hd};
    end
  end

  // fields not marked mode-specific read the same in both modes
  always_comb begin
    unique case (off)
      OFF_STATUS_A: rd_nxt = PS2_MODE ? status_a : RD_ABSENT;
      OFF_STATUS_B: rd_nxt = PS2_MODE ? status_b : RD_ABSENT;
      OFF_DIGITAL_OUTPUT: rd_nxt = dor_r;
      OFF_TAPE_DRIVE: rd_nxt = tape_rd;
      OFF_MAIN_STATUS: rd_nxt = main_status;
      OFF_DATA_FIFO: rd_nxt = last_byte_r;
      OFF_NONE: rd_nxt = RD_UNMAPPED;
      OFF_DIGITAL_INPUT: rd_nxt = dir_rd;
    endcase
  end

  io_rsp_t rsp_r;

  always_ff @(posedge CLK_SYS or negedge rst_n_r) begin
    if (!rst_n_r) begin
      rsp_r <= '0;
    end else begin
      rsp_r.ack <= hit && (IO_REQ.rd || IO_REQ.wr);
      rsp_r.rdata <= rd_hit ? rd_nxt : 8'h00;
    end
  end

  assign IO_RSP = rsp_r;

  ////////////////////////////////////////////////////////////////////////////
  // drive side outputs; only drive 0 and one rate line exist

  logic sel0_n_r;
  logic motor0_n_r;

  always_ff @(posedge CLK_SYS or negedge rst_n_r) begin
    if (!rst_n_r) begin
      sel0_n_r <= 1'b1;
      motor0_n_r <= 1'b1;
    end else begin
      // second select, second motor and high rate have no pin
      sel0_n_r <= !(dor_r[1:0] == 2'h0 && dor_r[DOR_MOTOR0]);
      motor0_n_r <= !dor_r[DOR_MOTOR0];
    end
  end

  logic ctrl_reset_r;

  always_ff @(posedge CLK_SYS or negedge rst_n_r) begin
    if (!rst_n_r) begin
      ctrl_reset_r <= 1'b1;
    end else begin
      ctrl_reset_r <= ctrl_reset;
    end
  end

  assign DRIVE_SELECT_0_N = sel0_n_r;
  assign MOTOR_ON_0_N = motor0_n_r;
  assign RATE_SELECT_LOW = rate_r[0];
  assign MFM_MODE = mfm_r;
  assign CTRL_RESET = ctrl_reset_r;
  assign LOW_POWER = low_power_r;

endmodule

/* fdc_regs_checker.sv */
// assertions on the host register bank ports
// assumes one clock and no request before the reset copy is released
`timescale 1ns/1ps
module fdc_regs_checker
  import fdc_regs_pkg::*;
#(
  parameter logic [15:0] BASE_ADDR = BASE_DEFAULT
) (
  input wire logic CLK_SYS,
  input wire logic RESETN,
  input wire io_req_t IO_REQ,
  input wire io_rsp_t IO_RSP,
  input wire logic PS2_MODE,
  input wire logic ENH_TAPE_MODE,
  input wire logic PINS_FLOATING,
  input wire logic RATE_SELECT_LOW
);
  logic hit;
  logic rdh;
  logic [2:0] off;
  assign hit = (IO_REQ.rd | IO_REQ.wr) && IO_REQ.addr[15:3] == BASE_ADDR[15:3];
  assign rdh = hit & IO_REQ.rd;
  assign off = IO_REQ.addr[2:0];
  default clocking @(posedge CLK_SYS);
  endclocking
  default disable iff (!RESETN);
  ////////////////////////////////////////////////////////////////////////////
  ack_on_hit_a: assert property (hit |=> IO_RSP.ack)
    else $error("no ack after a hit");
  ack_only_hit_a: assert property (IO_RSP.ack |-> $past(hit))
    else $error("ack without a hit");
  empty_slot_a: assert property (rdh && off == 3'h6 |=> IO_RSP.rdata == 8'h00)
    else $error("offset six read not zero");
  // mode levels may be synchronised, so wait for them to settle
  absent_status_a: assert property ((!PS2_MODE)[*4] ##0 (rdh && off < 3'h2)
    |=> IO_RSP.rdata == 8'hff) else $error("status read in PC-AT not ff");
  atmode_input_a: assert property ((!PS2_MODE)[*4] ##0 (rdh && off == 3'h7)
    |=> IO_RSP.rdata[6:0] == 7'h00) else $error("PC-AT input reserved bits set");
  tape_ones_a: assert property (ENH_TAPE_MODE[*4] ##0 (rdh && off == 3'h3)
    |=> IO_RSP.rdata[7:4] == 4'hf) else $error("tape upper bits not ones");
  float_ones_a: assert property (PINS_FLOATING[*6] ##0 (rdh && off == 3'h7)
    |=> IO_RSP.rdata[7]) else $error("floating change pin not one");
  status_rsvd_a: assert property (rdh && off == 3'h4
    |=> IO_RSP.rdata[6:5] == 2'h0 && IO_RSP.rdata[3:0] == 4'h0)
    else $error("main status reserved bits set");
  rate_write_a: assert property (hit && IO_REQ.wr && (off == 3'h4 || off == 3'h7)
    ##1 !IO_REQ.wr |=> RATE_SELECT_LOW == $past(IO_REQ.wdata[0], 2))
    else $error("rate bit not taken from write");
  gap_c: cover property (rdh && off == 3'h6);
  rate_c: cover property (hit && IO_REQ.wr && off == 3'h4);
  tape_c: cover property (ENH_TAPE_MODE && rdh && off == 3'h3);
endmodule
bind fdc_host_regs fdc_regs_checker #(.BASE_ADDR(BASE_ADDR)) fdc_regs_checker_inst (
  .CLK_SYS(CLK_SYS), .RESETN(RESETN), .IO_REQ(IO_REQ), .IO_RSP(IO_RSP),
  .PS2_MODE(PS2_MODE), .ENH_TAPE_MODE(ENH_TAPE_MODE), .PINS_FLOATING(PINS_FLOATING),
  .RATE_SELECT_LOW(RATE_SELECT_LOW)
);

/* fdc_regs_pkg.sv */
// constants and carrier types for the diskette controller host register bank
// assumes the host side hands over decoded I/O cycles one at a time
package fdc_regs_pkg;

  localparam logic [15:0] BASE_ALIGN_MASK = 16'h0007;
  localparam logic [15:0] BASE_DEFAULT = 16'h03f0;

  localparam logic [2:0] OFF_STATUS_A = 3'h0;
  localparam logic [2:0] OFF_STATUS_B = 3'h1;
  localparam logic [2:0] OFF_DIGITAL_OUTPUT = 3'h2;
  localparam logic [2:0] OFF_TAPE_DRIVE = 3'h3;
  localparam logic [2:0] OFF_MAIN_STATUS = 3'h4;
  localparam logic [2:0] OFF_DATA_FIFO = 3'h5;
  localparam logic [2:0] OFF_NONE = 3'h6;
  localparam logic [2:0] OFF_DIGITAL_INPUT = 3'h7;

  localparam logic [7:0] RST_DIGITAL_OUTPUT = 8'h00;
  localparam logic [1:0] RST_TAPE_SELECT = 2'h0;
  localparam logic [1:0] RST_EXCHANGE = 2'h0;
  localparam logic [1:0] RST_RATE = 2'h2;
  localparam logic [2:0] RST_PRECOMP = 3'h0;
  localparam logic [7:0] RD_UNMAPPED = 8'h00;
  localparam logic [7:0] RD_ABSENT = 8'hff;
  localparam logic [3:0] TAPE_UPPER_ONES = 4'hf;

  // digital output fields
  localparam int DOR_SEL = 0;
  localparam int DOR_RESET_N = 2;
  localparam int DOR_MOTOR0 = 4;
  localparam int DOR_MOTOR1 = 5;
  // data rate select fields
  localparam int DSR_RATE = 0;
  localparam int DSR_PRECOMP = 2;
  localparam int DSR_LOW_POWER = 6;
  localparam int DSR_SW_RESET = 7;
  // first command byte encoding bit
  localparam int CMD_MFM_BIT = 6;
  localparam logic [3:0] CMD_BYTES = 4'h9;

  // synchronised drive pins
  localparam int PIN_INDEX = 0;
  localparam int PIN_TRACK0 = 1;
  localparam int PIN_WPROT = 2;
  localparam int PIN_CHANGED = 3;
  localparam int NUM_PINS = 4;

  typedef struct packed {
    logic [15:0] addr;
    logic rd;
    logic wr;
    logic [7:0] wdata;
  } io_req_t;

  typedef struct packed {
    logic ack;
    logic [7:0] rdata;
  } io_rsp_t;

endpackage

/* host_model.sv */
// host side model issuing decoded I/O cycles to the register bank
// assumes the bank answers exactly one cycle after it takes a request
`timescale 1ns/1ps
module host_model
  import fdc_regs_pkg::*;
#(
  parameter logic [15:0] BASE_ADDR = BASE_DEFAULT
) (
  input wire logic clk,
  output io_req_t req,
  input wire io_rsp_t rsp
);
  initial req = '0;
  ////////////////////////////////////////////////////////////////////////////
  // one-cycle pulse; idle address and data show the inverse, never a stale copy
  task automatic cycle(input logic rd, input logic [15:0] off, input logic [7:0] d,
      output logic [7:0] q, output logic ok);
    @(posedge clk);
    req <= '{addr: BASE_ADDR + off, rd: rd, wr: !rd, wdata: d};
    @(posedge clk);
    req <= '{addr: ~(BASE_ADDR + off), rd: 1'b0, wr: 1'b0, wdata: ~d};
    @(posedge clk);
    ok = rsp.ack;
    q = rsp.rdata;
  endtask
endmodule

/* tb_top.sv */
// self-checking bench for the diskette host register bank
// assumes the host model is the only master on the register bus
`timescale 1ns/1ps
`define CHK(nm, e, s) \
  begin \
    n_checks++; \
    if ((e) !== (s)) begin \
      errors++; \
      $display("mismatch %s expected %h seen %h", nm, e, s); \
    end \
  end
module tb_top
  import fdc_regs_pkg::*;
;
  typedef struct packed {logic rd; logic [2:0] off; logic [7:0] d; logic [7:0] e;} row_t;
  localparam logic [3:0] NCMD = 4'h9;
  localparam row_t ROWS [14] = '{
    '{1'b1, 3'h4, 8'h00, 8'h00}, '{1'b1, 3'h0, 8'h00, 8'hff}, '{1'b1, 3'h1, 8'h00, 8'hff},
    '{1'b0, 3'h2, 8'h14, 8'h00}, '{1'b1, 3'h2, 8'h00, 8'h14}, '{1'b0, 3'h3, 8'h03, 8'h00},
    '{1'b1, 3'h3, 8'h00, 8'h03}, '{1'b0, 3'h6, 8'haa, 8'h00}, '{1'b1, 3'h6, 8'h00, 8'h00},
    '{1'b0, 3'h5, 8'h55, 8'h00}, '{1'b1, 3'h5, 8'h00, 8'h55}, '{1'b1, 3'h4, 8'h00, 8'h90},
    '{1'b1, 3'h7, 8'h00, 8'h00}, '{1'b0, 3'h4, 8'h02, 8'h00}};
  logic clk;
  logic resetn;
  logic ps2, enh, flt, chg_n;
  logic sel_n, mot_n, rate_lo, mfm, ctl_rst, low_pwr;
  logic [7:0] q;
  logic ok;
  io_req_t req;
  io_rsp_t rsp;
  int errors = 0;
  int n_checks = 0;
  int cycles = 0;
  host_model host_model_inst (.clk(clk), .req(req), .rsp(rsp));
  fdc_host_regs #(.COMMAND_BYTES(NCMD)) fdc_host_regs_inst (
    .CLK_SYS(clk), .RESETN(resetn), .IO_REQ(req), .IO_RSP(rsp), .PS2_MODE(ps2),
    .ENH_TAPE_MODE(enh), .PINS_FLOATING(flt), .INDEX_N(1'b1), .TRACK0_N(1'b1),
    .WRITE_PROTECT_N(1'b1), .DISK_CHANGED_N(chg_n), .DRIVE_SELECT_0_N(sel_n),
    .MOTOR_ON_0_N(mot_n), .RATE_SELECT_LOW(rate_lo), .MFM_MODE(mfm),
    .CTRL_RESET(ctl_rst), .LOW_POWER(low_pwr));
  ////////////////////////////////////////////////////////////////////////////
  task automatic io(input logic rd, input logic [2:0] off, input logic [7:0] d,
      input logic [7:0] e);
    host_model_inst.cycle(rd, {13'h0, off}, d, q, ok);
    `CHK("ack", 1'b1, ok)
    `CHK("rdata", e, q)
  endtask
  task automatic give_verdict();
    $display("checks %0d errors %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // ceiling well above the 140 or so cycles the sequence needs
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      errors++;
      give_verdict();
    end
  end
  initial begin
    {resetn, ps2, enh, flt, chg_n} = 5'h01;
    repeat (8) @(posedge clk);
    resetn <= 1'b1;
    repeat (3) @(posedge clk);
    `CHK("ctl_rst", 1'b1, ctl_rst)
    foreach (ROWS[i]) begin
      io(ROWS[i].rd, ROWS[i].off, ROWS[i].d, ROWS[i].e);
    end
    `CHK("sel_n", 1'b0, sel_n)
    `CHK("mot_n", 1'b0, mot_n)
    `CHK("ctl_rst", 1'b0, ctl_rst)
    io(1'b0, 3'h7, 8'h03, 8'h00);
    `CHK("rate_lo", 1'b1, rate_lo)
    `CHK("mfm", 1'b1, mfm)
    // parameter bytes clear bit 6: only a command byte may move the encoding
    for (int k = 1; k < NCMD; k++) begin
      io(1'b0, 3'h5, 8'h00, 8'h00);
    end
    `CHK("mfm", 1'b1, mfm)
    io(1'b0, 3'h5, 8'h06, 8'h00);
    `CHK("mfm", 1'b0, mfm)
    // low power: a rate write setting it again keeps it, a rate write with bit 6 clear wakes
    io(1'b0, 3'h4, 8'h43, 8'h00);
    `CHK("low_pwr", 1'b1, low_pwr)
    io(1'b0, 3'h4, 8'h43, 8'h00);
    `CHK("low_pwr", 1'b1, low_pwr)
    io(1'b0, 3'h4, 8'h83, 8'h00);
    `CHK("low_pwr", 1'b0, low_pwr)
    // soft reset drops the half-taken command, so busy clears
    io(1'b1, 3'h4, 8'h00, 8'h80);
    host_model_inst.cycle(1'b1, 16'h0008, 8'h00, q, ok);
    `CHK("miss ack", 1'b0, ok)
    ps2 <= 1'b1;
    repeat (4) @(posedge clk);
    io(1'b1, 3'h7, 8'h00, 8'h07);
    io(1'b1, 3'h1, 8'h00, 8'h01);
    io(1'b1, 3'h0, 8'h00, 8'h00);
    chg_n <= 1'b0;
    repeat (4) @(posedge clk);
    io(1'b1, 3'h7, 8'h00, 8'h87);
    chg_n <= 1'b1;
    flt <= 1'b1;
    repeat (6) @(posedge clk);
    io(1'b1, 3'h0, 8'h00, 8'h16);
    io(1'b1, 3'h7, 8'h00, 8'h87);
    enh <= 1'b1;
    repeat (4) @(posedge clk);
    io(1'b0, 3'h3, 8'h0e, 8'h00);
    io(1'b1, 3'h3, 8'h00, 8'hfe);
    give_verdict();
  end
endmodule
